// ### rtl/pmrs_pkg.sv
// Purpose: Constants and types for the power mode and reset sequencer
// Assumes: One 25 MHz clock drives all sequencing logic
// Notes: Mode field encodings and wait times live here only
package pmrs_pkg;
    // Operating-mode field encodings
    localparam logic [1:0] OPM_RUN = 2'h0;
    localparam logic [1:0] OPM_HALT = 2'h1;
    localparam logic [1:0] OPM_STANDBY = 2'h2;
    // Status flag bit positions
    localparam int PD_BIT = 3;
    localparam int TO_BIT = 4;
    // Interrupt vector used on wake-up with interrupts enabled
    localparam logic [11:0] WAKE_VECTOR = 12'h008;
    // Clock and wait figures
    localparam int CLK_HZ = 25000000;
    localparam int HALT_WAKE_CYCLES = 16;
    localparam int OST_CYCLES = 16;
    // Power-up wait times in nanoseconds
    localparam int PWRUP_T0_NS = 140000;
    localparam int PWRUP_T1_NS = 4500000;
    localparam int PWRUP_T2_NS = 18000000;
    localparam int PWRUP_T3_NS = 72000000;
    localparam int PWRUP_T4_NS = 288000000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    // Least times round up to whole cycles
    localparam int PWRUP_C0 = (PWRUP_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_C1 = (PWRUP_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_C2 = (PWRUP_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_C3 = (PWRUP_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_C4 = (PWRUP_T4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    // Sequencer states, Gray coded along reset -> wait -> ost -> run
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_PWRUP = 3'h1,
        ST_OST = 3'h3,
        ST_RUN = 3'h2,
        ST_STANDBY = 3'h6,
        ST_HALT = 3'h7,
        ST_HWAKE = 3'h5
    } pmrs_state_t;
endpackage : pmrs_pkg

// ### rtl/pmrs_counter.sv
// Purpose: Loadable down-counter that flags when a wait has elapsed
// Assumes: Load may come in the same cycle as run; load wins
// Notes: Done is a level that stands until the next load
module pmrs_counter #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic run,
    // Status
    output logic done
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic done_reg;
    logic done_next;

    if (WIDTH < 5) begin : g_width_chk
        $error("pmrs_counter width too small");
    end

    // Count down while running, stop at one
    always_comb begin
        count_next = count_reg;
        done_next = done_reg;
        if (load) begin
            count_next = load_value;
            done_next = 1'b0;
        end else if (run && !done_reg) begin
            if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                done_next = 1'b1;
            end else begin
                count_next = count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Register stage
    always_ff @(posedge clock) begin
        if (srst) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
endmodule : pmrs_counter

// ### rtl/pmrs_sequencer.sv
// Purpose: Low-power mode control and reset sequencing for a small MCU
// Assumes: All event inputs are synchronous to clock; all but the reset events are single-cycle pulses
// Notes: Power-up time is chosen by a three-bit setting, codes above 4 use the longest
module pmrs_sequencer (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Reset event sources
    input wire logic power_on_detect,
    input wire logic low_voltage_reset,
    input wire logic ext_reset_n,
    input wire logic watchdog_reset,
    // Configuration
    input wire logic [2:0] pwrup_time_sel,
    input wire logic startup_high_osc,
    // CPU writes to the oscillator control field
    input wire logic osc_ctrl_write,
    input wire logic [1:0] op_mode_wdata,
    input wire logic stop_high_osc_wdata,
    input wire logic high_osc_select_wdata,
    // CPU instructions
    input wire logic halt_instr,
    input wire logic watchdog_clear_instr,
    input wire logic irq_enable_instr,
    input wire logic irq_disable_instr,
    // Wake-up events
    input wire logic timer0_overflow,
    input wire logic timer1_underflow,
    input wire logic watchdog_timeout,
    input wire logic portb_change,
    input wire logic ext_interrupt,
    input wire logic low_voltage_detect,
    // Peripheral enables from software
    input wire logic timer0_enable,
    input wire logic timer1_enable,
    input wire logic periph_enable,
    // Control and status
    output logic [1:0] op_mode_sel,
    output logic stop_high_osc,
    output logic high_osc_select,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic irq_global_enable,
    // Clock and execution control
    output logic high_osc_run,
    output logic low_osc_run,
    output logic system_clock_high,
    output logic cpu_run,
    output logic cpu_in_reset,
    output logic watchdog_clear,
    output logic wake_vector_req,
    output logic [11:0] wake_vector,
    // Peripheral gating
    output logic timer0_run,
    output logic timer1_run,
    output logic periph_run
);
    ////////////////////////////////////////////////////////////////////////
    // State and registers
    pmrs_pkg::pmrs_state_t state_reg, state_next;
    logic [1:0] mode_reg, mode_next;
    logic stop_reg, stop_next;
    logic hsel_reg, hsel_next;
    logic to_reg, to_next;
    logic pd_reg, pd_next;
    logic gie_reg, gie_next;
    logic wdclr_reg, wdclr_next;
    logic vreq_reg, vreq_next;
    logic hosc_reg, hosc_next;
    logic losc_reg, losc_next;
    logic t0_reg, t0_next;
    logic t1_reg, t1_next;
    logic per_reg, per_next;
    logic cnt_load;
    logic cnt_run;
    logic cnt_done;
    logic [pmrs_pkg::CNT_W-1:0] cnt_value;
    logic reset_event;
    logic in_halt;

    // Power-up count for a given selection code
    function automatic logic [pmrs_pkg::CNT_W-1:0] pwrup_count(input logic [2:0] sel);
        case (sel)
            3'h0: pwrup_count = pmrs_pkg::CNT_W'(pmrs_pkg::PWRUP_C0);
            3'h1: pwrup_count = pmrs_pkg::CNT_W'(pmrs_pkg::PWRUP_C1);
            3'h2: pwrup_count = pmrs_pkg::CNT_W'(pmrs_pkg::PWRUP_C2);
            3'h3: pwrup_count = pmrs_pkg::CNT_W'(pmrs_pkg::PWRUP_C3);
            default: pwrup_count = pmrs_pkg::CNT_W'(pmrs_pkg::PWRUP_C4);
        endcase
    endfunction : pwrup_count

    ////////////////////////////////////////////////////////////////////////
    // Shared wait counter for power-up, start-up and halt wake
    pmrs_counter #(
        .WIDTH(pmrs_pkg::CNT_W)
    ) u_wait (
        .clock(clock),
        .srst(srst),
        .load(cnt_load),
        .load_value(cnt_value),
        .run(cnt_run),
        .done(cnt_done)
    );

    assign reset_event = power_on_detect | low_voltage_reset | !ext_reset_n
        | watchdog_reset;
    assign in_halt = (state_reg == pmrs_pkg::ST_HALT) || (state_reg == pmrs_pkg::ST_HWAKE);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        stop_next = stop_reg;
        hsel_next = hsel_reg;
        to_next = to_reg;
        pd_next = pd_reg;
        gie_next = gie_reg;
        wdclr_next = 1'b0;
        vreq_next = 1'b0;
        cnt_load = 1'b0;
        cnt_run = 1'b0;
        cnt_value = pwrup_count(pwrup_time_sel);
        if (reset_event) begin
            // Flags follow the cause; a held event keeps what its onset set
            if (power_on_detect || low_voltage_reset) begin
                to_next = 1'b1;
                pd_next = 1'b1;
            end else if (watchdog_reset) begin
                to_next = 1'b0;
                pd_next = (state_reg == pmrs_pkg::ST_RESET) ? pd_reg : !in_halt;
            end else if (in_halt) begin
                to_next = 1'b1;
                pd_next = 1'b1;
            end
            state_next = pmrs_pkg::ST_RESET;
            mode_next = pmrs_pkg::OPM_RUN;
            stop_next = 1'b0;
            gie_next = 1'b0;
        end else begin
            case (state_reg)
                pmrs_pkg::ST_RESET: begin
                    // Release: start the power-up wait
                    cnt_load = 1'b1;
                    hsel_next = startup_high_osc;
                    state_next = pmrs_pkg::ST_PWRUP;
                end
                pmrs_pkg::ST_PWRUP: begin
                    cnt_run = 1'b1;
                    if (cnt_done) begin
                        cnt_load = 1'b1;
                        cnt_value = pmrs_pkg::CNT_W'(pmrs_pkg::OST_CYCLES);
                        state_next = pmrs_pkg::ST_OST;
                    end
                end
                pmrs_pkg::ST_OST: begin
                    cnt_run = 1'b1;
                    if (cnt_done) begin
                        state_next = pmrs_pkg::ST_RUN;
                    end
                end
                pmrs_pkg::ST_RUN: begin
                    if (irq_enable_instr) begin
                        gie_next = 1'b1;
                    end else if (irq_disable_instr) begin
                        gie_next = 1'b0;
                    end
                    if (watchdog_clear_instr) begin
                        to_next = 1'b1;
                        pd_next = 1'b1;
                        wdclr_next = 1'b1;
                    end
                    if (halt_instr) begin
                        to_next = 1'b1;
                        pd_next = 1'b0;
                        wdclr_next = 1'b1;
                        mode_next = pmrs_pkg::OPM_HALT;
                        state_next = pmrs_pkg::ST_HALT;
                    end else if (osc_ctrl_write) begin
                        // Stop bit and mode land in the same write
                        stop_next = stop_high_osc_wdata;
                        hsel_next = high_osc_select_wdata;
                        mode_next = op_mode_wdata;
                        if (op_mode_wdata == pmrs_pkg::OPM_HALT) begin
                            to_next = 1'b1;
                            pd_next = 1'b0;
                            wdclr_next = 1'b1;
                            state_next = pmrs_pkg::ST_HALT;
                        end else if (op_mode_wdata == pmrs_pkg::OPM_STANDBY) begin
                            state_next = pmrs_pkg::ST_STANDBY;
                        end
                    end
                end
                pmrs_pkg::ST_STANDBY: begin
                    if (timer0_overflow || timer1_underflow || watchdog_timeout
                        || portb_change || ext_interrupt || low_voltage_detect) begin
                        mode_next = pmrs_pkg::OPM_RUN;
                        vreq_next = gie_reg;
                        state_next = pmrs_pkg::ST_RUN;
                    end
                end
                pmrs_pkg::ST_HALT: begin
                    if (watchdog_timeout || portb_change || ext_interrupt) begin
                        cnt_load = 1'b1;
                        cnt_value = pmrs_pkg::CNT_W'(pmrs_pkg::HALT_WAKE_CYCLES);
                        state_next = pmrs_pkg::ST_HWAKE;
                    end
                end
                pmrs_pkg::ST_HWAKE: begin
                    cnt_run = 1'b1;
                    if (cnt_done) begin
                        mode_next = pmrs_pkg::OPM_RUN;
                        vreq_next = gie_reg;
                        state_next = pmrs_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_next = pmrs_pkg::ST_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator and peripheral gating from the next state
    always_comb begin
        hosc_next = 1'b1;
        losc_next = 1'b1;
        t0_next = timer0_enable;
        t1_next = timer1_enable;
        per_next = periph_enable;
        // Stop bit may only stop the high osc while slow mode is selected
        if (stop_next && !hsel_next) begin
            hosc_next = 1'b0;
        end
        if (state_next == pmrs_pkg::ST_HALT) begin
            hosc_next = 1'b0;
            losc_next = 1'b0;
            t0_next = 1'b0;
            t1_next = 1'b0;
            per_next = 1'b0;
        end else if (state_next == pmrs_pkg::ST_STANDBY) begin
            per_next = periph_enable;
        end else if (state_next != pmrs_pkg::ST_RUN) begin
            // Restart paths keep the oscillators up for settling; halt wake keeps the high osc off if stopped in slow mode
            t0_next = 1'b0;
            t1_next = 1'b0;
            per_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register stage
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= pmrs_pkg::ST_RESET;
            mode_reg <= pmrs_pkg::OPM_RUN;
            stop_reg <= 1'b0;
            hsel_reg <= 1'b1;
            to_reg <= 1'b1;
            pd_reg <= 1'b1;
            gie_reg <= 1'b0;
            wdclr_reg <= 1'b0;
            vreq_reg <= 1'b0;
            hosc_reg <= 1'b1;
            losc_reg <= 1'b1;
            t0_reg <= 1'b0;
            t1_reg <= 1'b0;
            per_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            stop_reg <= stop_next;
            hsel_reg <= hsel_next;
            to_reg <= to_next;
            pd_reg <= pd_next;
            gie_reg <= gie_next;
            wdclr_reg <= wdclr_next;
            vreq_reg <= vreq_next;
            hosc_reg <= hosc_next;
            losc_reg <= losc_next;
            t0_reg <= t0_next;
            t1_reg <= t1_next;
            per_reg <= per_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops, except state decodes cpu_run, cpu_in_reset and the constant wake_vector
    assign op_mode_sel = mode_reg;
    assign stop_high_osc = stop_reg;
    assign high_osc_select = hsel_reg;
    assign timeout_flag = to_reg;
    assign power_down_flag = pd_reg;
    assign irq_global_enable = gie_reg;
    assign high_osc_run = hosc_reg;
    assign low_osc_run = losc_reg;
    assign system_clock_high = hsel_reg;
    assign cpu_run = (state_reg == pmrs_pkg::ST_RUN);
    assign cpu_in_reset = (state_reg == pmrs_pkg::ST_RESET) || (state_reg == pmrs_pkg::ST_PWRUP)
        || (state_reg == pmrs_pkg::ST_OST);
    assign watchdog_clear = wdclr_reg;
    assign wake_vector_req = vreq_reg;
    assign wake_vector = pmrs_pkg::WAKE_VECTOR;
    assign timer0_run = t0_reg;
    assign timer1_run = t1_reg;
    assign periph_run = per_reg;
endmodule : pmrs_sequencer

// ### sim/pmrs_wake_src.sv
// Purpose: Wake event source standing in for timers, pins and detectors
// Assumes: Bench raises fire for one cycle off the falling edge
// Notes: Bit 0 timer0 overflow up to bit 5 low-voltage detect
module pmrs_wake_src (
    // Clock
    input wire logic clock,
    // Request from the bench
    input wire logic fire,
    input wire logic [2:0] which,
    // Wake pulses
    output logic [5:0] wake
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pend;
    // Quiet lines until asked
    initial begin
        pend = 4'h0;
        wake = 6'h00;
    end
    // Latch on the rising edge so the bench's own edge cannot race it
    always @(posedge clock) begin
        pend <= {fire, which};
    end
    // One-cycle pulse launched mid-cycle, settled when the block samples
    always @(negedge clock) begin
        wake <= pend[3] ? (6'h01 << pend[2:0]) : 6'h00;
    end
endmodule : pmrs_wake_src

// ### sim/pmrs_sequencer_asserts.sv
// Purpose: Port-level assertions for the power mode and reset sequencer
// Assumes: One clock, srst synchronous and active high
// Notes: Halt idle is seen as the low oscillator stopped outside reset
module pmrs_sequencer_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Causes
    input wire logic power_on_detect,
    input wire logic low_voltage_reset,
    input wire logic ext_reset_n,
    input wire logic watchdog_reset,
    input wire logic osc_ctrl_write,
    input wire logic [1:0] op_mode_wdata,
    input wire logic high_osc_select_wdata,
    input wire logic halt_instr,
    input wire logic watchdog_clear_instr,
    input wire logic timer0_overflow,
    input wire logic timer1_underflow,
    input wire logic watchdog_timeout,
    input wire logic portb_change,
    input wire logic ext_interrupt,
    input wire logic low_voltage_detect,
    input wire logic timer0_enable,
    // Effects
    input wire logic [1:0] op_mode_sel,
    input wire logic stop_high_osc,
    input wire logic high_osc_select,
    input wire logic timeout_flag,
    input wire logic power_down_flag,
    input wire logic irq_global_enable,
    input wire logic high_osc_run,
    input wire logic low_osc_run,
    input wire logic system_clock_high,
    input wire logic cpu_run,
    input wire logic cpu_in_reset,
    input wire logic wake_vector_req,
    input wire logic [11:0] wake_vector,
    input wire logic timer0_run,
    input wire logic timer1_run,
    input wire logic periph_run
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    // Event groups; a reset event must mask every other next-cycle relation
    wire rst_ev = power_on_detect | low_voltage_reset | !ext_reset_n | watchdog_reset;
    wire halt_ok = watchdog_timeout | portb_change | ext_interrupt;
    wire sby_ok = halt_ok | timer0_overflow | timer1_underflow | low_voltage_detect;
    wire in_sby = op_mode_sel == 2'h2 && !cpu_run;
    wire in_halt = !low_osc_run && !cpu_in_reset;
    // Halt entry request and the 16-cycle settle before running
    sequence s_enter_halt;
        cpu_run && !rst_ev && (halt_instr || osc_ctrl_write && op_mode_wdata == 2'h1);
    endsequence
    sequence s_wake_wait;
        !cpu_run [*8] ##1 !cpu_run [*8] ##[1:4] cpu_run;
    endsequence
    ////////////////////////////////////////////////////////////
    chk_standby_entry: assert property (cpu_run && !rst_ev && !halt_instr && osc_ctrl_write
        && op_mode_wdata == 2'h2 |=> op_mode_sel == 2'h2 && !cpu_run) else $error("standby entry");
    chk_standby_clocks: assert property (in_sby && !stop_high_osc
        |-> high_osc_run && low_osc_run) else $error("standby clocks");
    chk_standby_timer: assert property (in_sby && $stable(timer0_enable)
        |-> timer0_run == timer0_enable) else $error("standby timer gate");
    chk_standby_wake: assert property (in_sby && sby_ok && !rst_ev |=> cpu_run
        && op_mode_sel == 2'h0 && system_clock_high == high_osc_select) else $error("standby wake");
    chk_halt_entry: assert property (s_enter_halt |=> !power_down_flag && timeout_flag
        && !low_osc_run && !high_osc_run) else $error("halt entry");
    chk_halt_gating: assert property (in_halt |-> !high_osc_run && !cpu_run
        && !timer0_run && !timer1_run && !periph_run) else $error("halt gating");
    chk_halt_ignore: assert property (in_halt && !halt_ok && !rst_ev
        |=> !low_osc_run) else $error("halt woke on wrong source");
    chk_halt_wake: assert property (in_halt && halt_ok && !rst_ev
        |=> s_wake_wait) else $error("halt wake timing");
    chk_wake_vector: assert property ($rose(cpu_run) && !$past(cpu_in_reset)
        |-> wake_vector_req == $past(irq_global_enable) && wake_vector == 12'h008)
        else $error("wake vector");
    chk_reset_flags: assert property (power_on_detect || low_voltage_reset
        |=> cpu_in_reset && !cpu_run && timeout_flag && power_down_flag) else $error("reset flags");
    chk_clear_flags: assert property (cpu_run && watchdog_clear_instr && !halt_instr
        && !osc_ctrl_write && !rst_ev |=> timeout_flag && power_down_flag) else $error("clear flags");
    chk_clock_select: assert property (cpu_run && osc_ctrl_write && op_mode_wdata == 2'h0
        && !halt_instr && !rst_ev |=> high_osc_select == $past(high_osc_select_wdata)
        && system_clock_high == high_osc_select) else $error("clock select");
endmodule : pmrs_sequencer_chk

bind pmrs_sequencer pmrs_sequencer_chk u_chk (.clock, .srst, .power_on_detect,
    .low_voltage_reset, .ext_reset_n, .watchdog_reset, .osc_ctrl_write, .op_mode_wdata,
    .high_osc_select_wdata, .halt_instr, .watchdog_clear_instr, .timer0_overflow,
    .timer1_underflow, .watchdog_timeout, .portb_change, .ext_interrupt, .low_voltage_detect,
    .timer0_enable, .op_mode_sel, .stop_high_osc, .high_osc_select, .timeout_flag,
    .power_down_flag, .irq_global_enable, .high_osc_run, .low_osc_run, .system_clock_high,
    .cpu_run, .cpu_in_reset, .wake_vector_req, .wake_vector, .timer0_run, .timer1_run,
    .periph_run);

// ### sim/testbench.sv
// Purpose: Self-checking bench for the power mode and reset sequencer
// Assumes: Inputs change on the falling edge, shortest power-up setting
// Notes: Each reset costs about 3500 cycles, so resets are few
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, srst, ext_reset_n, startup_high_osc, osc_ctrl_write, stp, hs, fire;
    logic [2:0] rc, en, pts, which;
    logic [3:0] ins;
    logic [1:0] opw, op_mode_sel;
    logic [5:0] wake;
    logic [11:0] wake_vector;
    logic stop_high_osc, high_osc_select, timeout_flag, power_down_flag, irq_global_enable;
    logic high_osc_run, low_osc_run, system_clock_high, cpu_run, cpu_in_reset;
    logic watchdog_clear, wake_vector_req, timer0_run, timer1_run, periph_run;
    int num_errors, n_checks, c;
    int lo = pmrs_pkg::PWRUP_C0 + pmrs_pkg::OST_CYCLES;
    int hw = pmrs_pkg::HALT_WAKE_CYCLES;
    // Flag steps: action before reset (1 = halt), reset cause, expected {to, pd}
    int pre[6] = '{0, 0, 1, 1, 0, 0};
    int cause[6] = '{3, 4, 4, 3, 2, 1};
    logic [1:0] fl[6] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h3, 2'h3};

    pmrs_sequencer u_dut (.clock, .srst, .power_on_detect(rc[0]), .low_voltage_reset(rc[1]),
        .ext_reset_n, .watchdog_reset(rc[2]), .pwrup_time_sel(pts), .startup_high_osc,
        .osc_ctrl_write, .op_mode_wdata(opw), .stop_high_osc_wdata(stp),
        .high_osc_select_wdata(hs), .halt_instr(ins[0]), .watchdog_clear_instr(ins[1]),
        .irq_enable_instr(ins[2]), .irq_disable_instr(ins[3]), .timer0_overflow(wake[0]),
        .timer1_underflow(wake[1]), .watchdog_timeout(wake[2]), .portb_change(wake[3]),
        .ext_interrupt(wake[4]), .low_voltage_detect(wake[5]), .timer0_enable(en[0]),
        .timer1_enable(en[1]), .periph_enable(en[2]), .op_mode_sel, .stop_high_osc,
        .high_osc_select, .timeout_flag, .power_down_flag, .irq_global_enable, .high_osc_run,
        .low_osc_run, .system_clock_high, .cpu_run, .cpu_in_reset, .watchdog_clear,
        .wake_vector_req, .wake_vector, .timer0_run, .timer1_run, .periph_run);
    pmrs_wake_src u_wake (.clock, .fire, .which, .wake);

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // Bounded wait for execution; a hang ends the run
    task automatic wait_run(input int lim);
        c = 0;
        while (cpu_run !== 1'b1 && c < lim) begin
            @(negedge clock);
            c++;
        end
        if (c >= lim) begin
            num_errors++;
            $display("[FAIL] cpu_run exp 1 got %b", cpu_run);
            print_verdict();
        end
    endtask : wait_run
    task automatic boot_wait();
        repeat (2) @(negedge clock);
        srst = 1'b0;
        rc = 3'h0;
        ext_reset_n = 1'b1;
        wait_run(4000);
        chk("boot time ok", 1, c >= lo && c <= lo + 6);
    endtask : boot_wait
    // Cause 0 srst, 1 power-on, 2 low voltage, 3 watchdog, 4 pin
    task automatic do_reset(input int k);
        @(negedge clock);
        srst = (k == 0);
        rc = {k == 3, k == 2, k == 1};
        ext_reset_n = (k != 4);
        boot_wait();
    endtask : do_reset
    task automatic wr(input logic [1:0] op, input logic s, input logic h);
        @(negedge clock);
        {osc_ctrl_write, opw, stp, hs} = {1'b1, op, s, h};
        @(negedge clock);
        osc_ctrl_write = 1'b0;
    endtask : wr
    // 0 halt, 1 watchdog clear, 2 enable, 3 disable interrupts
    task automatic pulse_ins(input int k);
        @(negedge clock);
        ins = 4'h1 << k;
        @(negedge clock);
        ins = 4'h0;
    endtask : pulse_ins
    task automatic fire_ev(input int k);
        @(negedge clock);
        fire = 1'b1;
        which = 3'(k);
        @(negedge clock);
        fire = 1'b0;
    endtask : fire_ev
    ////////////////////////////////////////////////////////////
    // Every standby wake source, normal then slow then slow with high osc stopped
    task automatic t_standby();
        en = 3'h7;
        for (int k = 0; k < 6; k++) begin
            pulse_ins((k % 2 == 0) ? 2 : 3);
            if (k == 3) wr(2'h0, 1'b0, 1'b0);
            if (k == 4) wr(2'h0, 1'b1, 1'b0);
            wr(2'h2, k >= 4, k < 3);
            @(negedge clock);
            chk("sby mode", 2'h2, op_mode_sel);
            chk("sby run", 5'h0f, {cpu_run, low_osc_run, timer0_run, timer1_run,
                periph_run});
            chk("sby hosc", k < 4, high_osc_run);
            fire_ev(k);
            wait_run(4);
            chk("sby wait", 1, c);
            chk("sby mode back", 2'h0, op_mode_sel);
            chk("sby clock", k < 3, system_clock_high);
            chk("sby vector", {k % 2 == 0, 12'h008}, {wake_vector_req, wake_vector});
        end
        wr(2'h0, 1'b0, 1'b0);
        wr(2'h0, 1'b0, 1'b1);
    endtask : t_standby
    // Halt by instruction and by mode write, ignored sources, then valid wakes
    task automatic t_halt();
        for (int k = 2; k < 5; k++) begin
            pulse_ins(1);
            if (k == 2) pulse_ins(0);
            else wr(2'h1, k == 4, 1'b1);
            @(negedge clock);
            chk("halt flags", 2'h2, {timeout_flag, power_down_flag});
            chk("halt gate", 6'h00, {high_osc_run, low_osc_run, cpu_run, timer0_run,
                timer1_run, periph_run});
            chk("halt stop bit", k == 4, stop_high_osc);
            fire_ev(0);
            fire_ev(5);
            @(negedge clock);
            chk("halt ignores", 2'h0, {low_osc_run, cpu_run});
            fire_ev(k);
            wait_run(40);
            chk("halt wake ok", 1, c >= hw && c <= hw + 4);
            chk("halt wake mode", 3'h1, {op_mode_sel, system_clock_high});
        end
        wr(2'h0, 1'b0, 1'b1);
    endtask : t_halt
    // Status flags per reset cause, watchdog clear, start-up clock choice
    task automatic t_flags();
        for (int i = 0; i < 6; i++) begin
            if (pre[i] == 1) pulse_ins(0);
            do_reset(cause[i]);
            chk("reset flags", fl[i], {timeout_flag, power_down_flag});
            if (i == 3) begin
                pulse_ins(1);
                chk("clear flags", 3'h7, {timeout_flag, power_down_flag, watchdog_clear});
            end
        end
        startup_high_osc = 1'b0;
        do_reset(0);
        chk("startup slow", 2'h0, {high_osc_select, system_clock_high});
    endtask : t_flags
    ////////////////////////////////////////////////////////////
    initial begin
        {rc, en, pts, which, ins, opw, osc_ctrl_write, stp, hs, fire} = '0;
        srst = 1'b1;
        ext_reset_n = 1'b1;
        startup_high_osc = 1'b1;
        num_errors = 0;
        n_checks = 0;
        boot_wait();
        chk("boot state", 3'h7, {timeout_flag, power_down_flag, high_osc_select});
        t_standby();
        t_halt();
        t_flags();
        print_verdict();
    end
endmodule : testbench
